// File: include/spectral_status_flags_cfg.svh
`ifndef SPECTRAL_STATUS_FLAGS_CFG_SVH
`define SPECTRAL_STATUS_FLAGS_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSF_MEAS_STATE_ADDR   8'h71
`define SSF_EVENT_STATUS_ADDR 8'h93
`define SSF_SAT_DETAIL_ADDR   8'hA3
`define SSF_EVENT_ENABLE_ADDR 8'hF8
`define SSF_IRQ_MASK_ADDR     8'hF9

// ----------------------------------------------------------------
// measurement state fields
// ----------------------------------------------------------------
`define SSF_MS_READY_BIT      0
`define SSF_MS_WAIT_SYNC_BIT  1
`define SSF_MS_SPARE_LSB      2
`define SSF_MS_SPARE_MSB      7

// ----------------------------------------------------------------
// event status fields, also used by enable and mask registers
// ----------------------------------------------------------------
`define SSF_EV_SYSTEM_BIT     0
`define SSF_EV_CALIB_BIT      1
`define SSF_EV_BUFFER_BIT     2
`define SSF_EV_THRESHOLD_BIT  3
`define SSF_EV_SATURATION_BIT 7
`define SSF_EV_IMPL_MASK      8'h8F

// ----------------------------------------------------------------
// saturation detail fields
// ----------------------------------------------------------------
`define SSF_SD_FLICKER_CNT_BIT  0
`define SSF_SD_FLICKER_FE_BIT   1
`define SSF_SD_SPEC_FE_BIT      3
`define SSF_SD_SPEC_CNT_BIT     4
`define SSF_SD_VALID_BIT        6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSF_MEAS_STATE_RST    8'h00
`define SSF_EVENT_STATUS_RST  8'h00
`define SSF_SAT_DETAIL_RST    8'h00
`define SSF_EVENT_ENABLE_RST  8'h00
`define SSF_IRQ_MASK_RST      8'h00

`endif

// File: include/spectral_status_pkg.sv
package spectral_status_pkg;

  typedef logic [7:0]  reg_byte_t;
  typedef logic [7:0]  reg_addr_t;
  typedef logic [15:0] result_t;
  typedef logic [3:0]  persist_t;

endpackage

// File: src/spectral_status_flags.sv
`timescale 1ns/10ps
`include "spectral_status_flags_cfg.svh"

module spectral_status_flags
  import spectral_status_pkg::*;
#(
  parameter int RESULT_WIDTH = 16
)
(
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  // register port
  input  wire spectral_status_pkg::reg_addr_t  ADDR,
  input  wire spectral_status_pkg::reg_byte_t  WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output      spectral_status_pkg::reg_byte_t  RDATA,
  // measurement engine state
  input  wire logic                          MEAS_BUSY,
  input  wire logic                          SYNC_WAIT,
  input  wire logic                          MEAS_START,
  input  wire logic                          MEAS_DONE,
  // saturation sources, one-cycle pulses
  input  wire logic                          SPECTRAL_COUNT_OVERFLOW,
  input  wire logic                          SPECTRAL_FRONTEND_OVERLOAD,
  input  wire logic                          FLICKER_COUNT_OVERFLOW,
  input  wire logic                          FLICKER_FRONTEND_OVERLOAD,
  // threshold comparison
  input  wire logic                          RESULT_STROBE,
  input  wire logic [RESULT_WIDTH-1:0]       RESULT,
  input  wire logic [RESULT_WIDTH-1:0]       LOW_THRESHOLD,
  input  wire logic [RESULT_WIDTH-1:0]       HIGH_THRESHOLD,
  input  wire spectral_status_pkg::persist_t   PERSISTENCE_COUNT,
  // buffer level
  input  wire logic                          BUFFER_WRITE,
  input  wire logic                          BUFFER_LEVEL_MET,
  // other event sources
  input  wire logic                          SYSTEM_EVENT,
  input  wire logic                          CALIB_EVENT,
  // interrupt
  output      logic                          IRQ
);
  import spectral_status_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [5:0] meas_spare;
  reg_byte_t  event_status;
  reg_byte_t  event_enable;
  reg_byte_t  irq_mask;
  logic       measurement_valid;
  logic       spectral_count_overflow;
  logic       spectral_frontend_overload;
  logic       flicker_count_overflow;
  logic       flicker_frontend_overload;
  persist_t   persist_run;
  logic       buffer_level_seen;

  logic       wr_meas;
  logic       wr_event;
  logic       wr_enable;
  logic       wr_mask;
  logic       out_of_range;
  logic       below_low;
  logic       above_high;
  logic       threshold_hit;
  logic       buffer_hit;
  logic       saturation_hit;
  persist_t   next_persist_run;
  reg_byte_t  event_set;
  reg_byte_t  event_clr;
  reg_byte_t  next_event_status;
  reg_byte_t  meas_state_view;
  reg_byte_t  sat_detail_view;
  reg_byte_t  next_rdata;

  assign wr_meas   = WR && (ADDR == `SSF_MEAS_STATE_ADDR);
  assign wr_event  = WR && (ADDR == `SSF_EVENT_STATUS_ADDR);
  assign wr_enable = WR && (ADDR == `SSF_EVENT_ENABLE_ADDR);
  assign wr_mask   = WR && (ADDR == `SSF_IRQ_MASK_ADDR);

  // ----------------------------------------------------------------
  // measurement state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      meas_spare <= 6'h0;
    else if (wr_meas)
      meas_spare <= WDATA[`SSF_MS_SPARE_MSB:`SSF_MS_SPARE_LSB];
  end

  always_comb
  begin
    meas_state_view = 8'h00;
    meas_state_view[`SSF_MS_SPARE_MSB:`SSF_MS_SPARE_LSB] = meas_spare;
    meas_state_view[`SSF_MS_WAIT_SYNC_BIT] = SYNC_WAIT;
    meas_state_view[`SSF_MS_READY_BIT] = ~MEAS_BUSY;
  end

  // ----------------------------------------------------------------
  // enable and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      event_enable <= `SSF_EVENT_ENABLE_RST;
    else if (wr_enable)
      event_enable <= WDATA & `SSF_EV_IMPL_MASK;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      irq_mask <= `SSF_IRQ_MASK_RST;
    else if (wr_mask)
      irq_mask <= WDATA & `SSF_EV_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // threshold persistence
  // ----------------------------------------------------------------
  // below low threshold
  assign below_low  = RESULT < LOW_THRESHOLD;
  assign above_high = RESULT > HIGH_THRESHOLD;
  assign out_of_range = below_low || above_high;

  always_comb
  begin
    next_persist_run = persist_run;
    if (RESULT_STROBE)
    begin
      if (!out_of_range)
        next_persist_run = 4'h0;
      else if (persist_run != 4'hF)
        next_persist_run = persist_run + 4'h1;
    end
  end

  // persistence reached
  // zero persistence raises on every result, like a free-running alarm
  assign threshold_hit = RESULT_STROBE &&
                         ((PERSISTENCE_COUNT == 4'h0) ||
                          (out_of_range && (next_persist_run >= PERSISTENCE_COUNT)));

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      persist_run <= 4'h0;
    else
      persist_run <= next_persist_run;
  end

  // ----------------------------------------------------------------
  // buffer level
  // ----------------------------------------------------------------
  // re-raise on each new entry while level holds
  assign buffer_hit = BUFFER_LEVEL_MET && (BUFFER_WRITE || !buffer_level_seen);

  // flag only dies once the host drains the buffer
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      buffer_level_seen <= 1'b0;
    else
      buffer_level_seen <= BUFFER_LEVEL_MET;
  end

  // ----------------------------------------------------------------
  // event status, sticky
  // ----------------------------------------------------------------
  assign saturation_hit = SPECTRAL_COUNT_OVERFLOW || SPECTRAL_FRONTEND_OVERLOAD ||
                          FLICKER_COUNT_OVERFLOW || FLICKER_FRONTEND_OVERLOAD;

  always_comb
  begin
    event_set = 8'h00;
    event_set[`SSF_EV_SATURATION_BIT] = saturation_hit &&
                                        event_enable[`SSF_EV_SATURATION_BIT];
    event_set[`SSF_EV_THRESHOLD_BIT]  = threshold_hit &&
                                        event_enable[`SSF_EV_THRESHOLD_BIT];
    event_set[`SSF_EV_BUFFER_BIT]     = buffer_hit &&
                                        event_enable[`SSF_EV_BUFFER_BIT];
    event_set[`SSF_EV_CALIB_BIT]      = CALIB_EVENT &&
                                        event_enable[`SSF_EV_CALIB_BIT];
    event_set[`SSF_EV_SYSTEM_BIT]     = SYSTEM_EVENT &&
                                        event_enable[`SSF_EV_SYSTEM_BIT];
  end

  // ones clear; zeros leave bits alone
  // write-back of a read value clears only handled events
  assign event_clr = wr_event ? WDATA : 8'h00;
  // set wins so an event in the clearing cycle survives
  assign next_event_status = ((event_status & ~event_clr) | event_set) &
                             `SSF_EV_IMPL_MASK;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      event_status <= `SSF_EVENT_STATUS_RST;
    else
      event_status <= next_event_status;
  end

  // ----------------------------------------------------------------
  // saturation detail and valid
  // ----------------------------------------------------------------
  // detail bits are dropped together with the saturation flag,
  // since the host has no way to write this register
  logic sat_clear;
  assign sat_clear = wr_event && WDATA[`SSF_EV_SATURATION_BIT];

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      spectral_count_overflow <= 1'b0;
    else if (SPECTRAL_COUNT_OVERFLOW)
      spectral_count_overflow <= 1'b1;
    else if (sat_clear)
      spectral_count_overflow <= 1'b0;
  end

  // analog cause kept apart from digital
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      spectral_frontend_overload <= 1'b0;
    else if (SPECTRAL_FRONTEND_OVERLOAD)
      spectral_frontend_overload <= 1'b1;
    else if (sat_clear)
      spectral_frontend_overload <= 1'b0;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      flicker_count_overflow <= 1'b0;
    else if (FLICKER_COUNT_OVERFLOW)
      flicker_count_overflow <= 1'b1;
    else if (sat_clear)
      flicker_count_overflow <= 1'b0;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      flicker_frontend_overload <= 1'b0;
    else if (FLICKER_FRONTEND_OVERLOAD)
      flicker_frontend_overload <= 1'b1;
    else if (sat_clear)
      flicker_frontend_overload <= 1'b0;
  end

  // valid after completion, dropped on next start
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      measurement_valid <= 1'b0;
    else if (MEAS_DONE)
      measurement_valid <= 1'b1;
    else if (MEAS_START)
      measurement_valid <= 1'b0;
  end

  // detail register has no write path
  always_comb
  begin
    sat_detail_view = `SSF_SAT_DETAIL_RST;
    sat_detail_view[`SSF_SD_VALID_BIT]       = measurement_valid;
    sat_detail_view[`SSF_SD_SPEC_CNT_BIT]    = spectral_count_overflow;
    sat_detail_view[`SSF_SD_SPEC_FE_BIT]     = spectral_frontend_overload;
    sat_detail_view[`SSF_SD_FLICKER_FE_BIT]  = flicker_frontend_overload;
    sat_detail_view[`SSF_SD_FLICKER_CNT_BIT] = flicker_count_overflow;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    if (RD)
    begin
      unique case (ADDR)
        `SSF_MEAS_STATE_ADDR:   next_rdata = meas_state_view;
        `SSF_EVENT_STATUS_ADDR: next_rdata = event_status;
        `SSF_SAT_DETAIL_ADDR:   next_rdata = sat_detail_view;
        `SSF_EVENT_ENABLE_ADDR: next_rdata = event_enable;
        `SSF_IRQ_MASK_ADDR:     next_rdata = irq_mask;
        default:                next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      RDATA <= 8'h00;
    else
      RDATA <= next_rdata;
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // one cycle behind the status flops, traded for a registered pin
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      IRQ <= 1'b0;
    else
      IRQ <= |(event_status & irq_mask);
  end

endmodule // spectral_status_flags

// File: test/host_port_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module host_port_model
  import spectral_status_pkg::*;
(
  // clock
  input  wire logic                           clk,
  // register port
  output spectral_status_pkg::reg_addr_t      addr,
  output spectral_status_pkg::reg_byte_t      wdata,
  output logic                                wr,
  output logic                                rd,
  input  wire spectral_status_pkg::reg_byte_t rdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // released lines show the inverse, never the stale value
  task automatic write_reg(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic read_reg(input reg_addr_t a, output reg_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask

  task automatic service(input reg_addr_t a, output reg_byte_t d);
    read_reg(a, d);
    write_reg(a, d);
  endtask
endmodule // host_port_model

// File: test/spectral_status_flags_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module spectral_status_flags_props
  import spectral_status_pkg::*;
(
  // clock and reset
  input wire logic                           CLK,
  input wire logic                           NRST,
  // register port
  input wire spectral_status_pkg::reg_addr_t ADDR,
  input wire spectral_status_pkg::reg_byte_t WDATA,
  input wire logic                           WR,
  input wire logic                           RD,
  input wire spectral_status_pkg::reg_byte_t RDATA,
  // measurement state and event sources
  input wire logic                           MEAS_BUSY,
  input wire logic                           SYNC_WAIT,
  input wire logic                           SPECTRAL_COUNT_OVERFLOW,
  input wire logic                           SPECTRAL_FRONTEND_OVERLOAD,
  input wire logic                           FLICKER_COUNT_OVERFLOW,
  input wire logic                           FLICKER_FRONTEND_OVERLOAD,
  input wire logic                           RESULT_STROBE,
  input wire logic                           BUFFER_WRITE,
  input wire logic                           BUFFER_LEVEL_MET,
  input wire logic                           SYSTEM_EVENT,
  input wire logic                           CALIB_EVENT,
  // interrupt
  input wire logic                           IRQ
);
  logic [7:0] en_copy;
  logic [7:0] mask_copy;
  logic       sat_any;
  logic       any_event;

  assign sat_any = SPECTRAL_COUNT_OVERFLOW | SPECTRAL_FRONTEND_OVERLOAD
                 | FLICKER_COUNT_OVERFLOW | FLICKER_FRONTEND_OVERLOAD;
  assign any_event = sat_any | RESULT_STROBE | BUFFER_WRITE | BUFFER_LEVEL_MET
                   | SYSTEM_EVENT | CALIB_EVENT;

  // shadow of enable and mask, hidden behind the port
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      en_copy <= 8'h00;
    else if (WR && ADDR == 8'hF8)
      en_copy <= WDATA;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      mask_copy <= 8'h00;
    else if (WR && ADDR == 8'hF9)
      mask_copy <= WDATA;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_ready_bit: assert property (
    RD && ADDR == 8'h71 |=> RDATA[0] == !$past(MEAS_BUSY)) else $error("ready bit wrong");
  a_sync_wait_bit: assert property (
    RD && ADDR == 8'h71 |=> RDATA[1] == $past(SYNC_WAIT)) else $error("sync wait bit wrong");
  a_system_irq: assert property (
    SYSTEM_EVENT && en_copy[0] && mask_copy[0] |-> ##2 IRQ) else $error("system irq missing");
  a_saturation_irq: assert property (
    sat_any && en_copy[7] && mask_copy[7] |-> ##2 IRQ) else $error("saturation irq missing");
  a_buffer_rise_irq: assert property (
    $rose(BUFFER_LEVEL_MET) && en_copy[2] && mask_copy[2] |-> ##2 IRQ)
    else $error("buffer irq missing");
  a_buffer_refill_irq: assert property (
    BUFFER_WRITE && BUFFER_LEVEL_MET && en_copy[2] && mask_copy[2] |-> ##2 IRQ)
    else $error("buffer refill irq missing");
  a_clear_all: assert property (
    (WR && ADDR == 8'h93 && WDATA == 8'hFF && !any_event) ##1 !any_event |=> !IRQ)
    else $error("clear did not drop irq");
  a_zero_keeps: assert property (
    IRQ && WR && ADDR == 8'h93 && WDATA == 8'h00 |=> IRQ) else $error("zero write cleared");
  a_masked_quiet: assert property (
    mask_copy == 8'h00 |=> !IRQ) else $error("irq while masked");
  a_unmapped_zero: assert property (
    RD && !(ADDR inside {8'h71, 8'h93, 8'hA3, 8'hF8, 8'hF9}) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule // spectral_status_flags_props

bind spectral_status_flags spectral_status_flags_props u_spectral_status_flags_props (
  .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .MEAS_BUSY(MEAS_BUSY), .SYNC_WAIT(SYNC_WAIT),
  .SPECTRAL_COUNT_OVERFLOW(SPECTRAL_COUNT_OVERFLOW),
  .SPECTRAL_FRONTEND_OVERLOAD(SPECTRAL_FRONTEND_OVERLOAD),
  .FLICKER_COUNT_OVERFLOW(FLICKER_COUNT_OVERFLOW),
  .FLICKER_FRONTEND_OVERLOAD(FLICKER_FRONTEND_OVERLOAD),
  .RESULT_STROBE(RESULT_STROBE), .BUFFER_WRITE(BUFFER_WRITE),
  .BUFFER_LEVEL_MET(BUFFER_LEVEL_MET), .SYSTEM_EVENT(SYSTEM_EVENT),
  .CALIB_EVENT(CALIB_EVENT), .IRQ(IRQ));

// File: test/test_spectral_status_flags.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("BAD %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_spectral_status_flags;
  import spectral_status_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  reg_addr_t  addr;
  reg_byte_t  wdata;
  logic       wr;
  logic       rd;
  reg_byte_t  rdata;
  logic       meas_busy = 1'b1;
  logic       sync_wait = 1'b0;
  logic [9:0] pulse_v = 10'h000;
  result_t    result = 16'h0000;
  result_t    low_th = 16'h0000;
  result_t    high_th = 16'hFFFF;
  persist_t   persist = 4'h0;
  logic       level_met = 1'b0;
  logic       irq;
  int         bad_count = 0;
  int         total_checks = 0;

  spectral_status_flags u_spectral_status_flags (
    .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MEAS_BUSY(meas_busy), .SYNC_WAIT(sync_wait), .MEAS_START(pulse_v[8]),
    .MEAS_DONE(pulse_v[9]), .SPECTRAL_COUNT_OVERFLOW(pulse_v[4]),
    .SPECTRAL_FRONTEND_OVERLOAD(pulse_v[5]), .FLICKER_COUNT_OVERFLOW(pulse_v[6]),
    .FLICKER_FRONTEND_OVERLOAD(pulse_v[7]), .RESULT_STROBE(pulse_v[3]), .RESULT(result),
    .LOW_THRESHOLD(low_th), .HIGH_THRESHOLD(high_th), .PERSISTENCE_COUNT(persist),
    .BUFFER_WRITE(pulse_v[2]), .BUFFER_LEVEL_MET(level_met), .SYSTEM_EVENT(pulse_v[0]),
    .CALIB_EVENT(pulse_v[1]), .IRQ(irq));

  host_port_model u_host_port_model (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  always #2.5 clk = ~clk;

  task automatic fire(input logic [9:0] v);
    @(posedge clk);
    pulse_v <= v;
    @(posedge clk);
    pulse_v <= 10'h000;
  endtask

  task automatic wr_reg(input reg_addr_t a, input reg_byte_t d);
    u_host_port_model.write_reg(a, d);
  endtask

  task automatic expect_reg(input reg_addr_t a, input reg_byte_t e);
    reg_byte_t got;
    u_host_port_model.read_reg(a, got);
    `CHK(got, e)
  endtask

  task automatic t_state();
    @(posedge clk);
    sync_wait <= 1'b1;
    expect_reg(8'h71, 8'h02);
    @(posedge clk);
    meas_busy <= 1'b0;
    sync_wait <= 1'b0;
    expect_reg(8'h71, 8'h01);
    wr_reg(8'h71, 8'hFF);
    expect_reg(8'h71, 8'hFD);
  endtask

  task automatic t_events();
    logic [9:0] src [6] = '{10'h001, 10'h002, 10'h010, 10'h020, 10'h040, 10'h080};
    reg_byte_t  st [6] = '{8'h01, 8'h02, 8'h80, 8'h80, 8'h80, 8'h80};
    reg_byte_t  dt [6] = '{8'h00, 8'h00, 8'h10, 8'h08, 8'h01, 8'h02};
    reg_byte_t  v;
    wr_reg(8'hF8, 8'h8F);
    wr_reg(8'hF9, 8'h8F);
    for (int i = 0; i < 6; i++)
    begin
      fire(src[i]);
      expect_reg(8'h93, st[i]);
      expect_reg(8'hA3, dt[i]);
      wr_reg(8'hA3, 8'hFF);
      wr_reg(8'h93, 8'h00);
      expect_reg(8'hA3, dt[i]);
      expect_reg(8'h93, st[i]);
      `CHK(irq, 1'b1)
      u_host_port_model.service(8'h93, v);
      expect_reg(8'h93, 8'h00);
      expect_reg(8'hA3, 8'h00);
      `CHK(irq, 1'b0)
    end
  endtask

  task automatic t_gating();
    wr_reg(8'hF8, 8'h00);
    fire(10'h001);
    expect_reg(8'h93, 8'h00);
    wr_reg(8'hF8, 8'h8F);
    wr_reg(8'hF9, 8'h00);
    fire(10'h010);
    expect_reg(8'h93, 8'h80);
    `CHK(irq, 1'b0)
    wr_reg(8'h93, 8'hFF);
    wr_reg(8'hF9, 8'h8F);
    expect_reg(8'h93, 8'h00);
  endtask

  task automatic t_threshold();
    @(posedge clk);
    low_th <= 16'h0100;
    persist <= 4'h2;
    result <= 16'h0050;
    fire(10'h008);
    expect_reg(8'h93, 8'h00);
    fire(10'h008);
    expect_reg(8'h93, 8'h08);
    wr_reg(8'h93, 8'h08);
    @(posedge clk);
    result <= 16'h0200;
    fire(10'h008);
    @(posedge clk);
    result <= 16'h0050;
    fire(10'h008);
    expect_reg(8'h93, 8'h00);
    // above the high threshold also counts as out of range
    @(posedge clk);
    high_th <= 16'h0300;
    persist <= 4'h1;
    result <= 16'h0400;
    fire(10'h008);
    expect_reg(8'h93, 8'h08);
    wr_reg(8'h93, 8'h08);
    // zero persistence raises on every strobe, in range too
    @(posedge clk);
    persist <= 4'h0;
    result <= 16'h0200;
    fire(10'h008);
    expect_reg(8'h93, 8'h08);
    wr_reg(8'h93, 8'h08);
    expect_reg(8'h93, 8'h00);
  endtask

  task automatic t_buffer();
    @(posedge clk);
    level_met <= 1'b1;
    expect_reg(8'h93, 8'h04);
    wr_reg(8'h93, 8'h04);
    expect_reg(8'h93, 8'h00);
    fire(10'h004);
    expect_reg(8'h93, 8'h04);
    @(posedge clk);
    level_met <= 1'b0;
    wr_reg(8'h93, 8'hFF);
    fire(10'h004);
    expect_reg(8'h93, 8'h00);
  endtask

  task automatic t_valid();
    fire(10'h100);
    expect_reg(8'hA3, 8'h00);
    fire(10'h200);
    expect_reg(8'hA3, 8'h40);
    wr_reg(8'hA3, 8'h00);
    expect_reg(8'hA3, 8'h40);
    // a new start drops the valid flag again
    fire(10'h100);
    expect_reg(8'hA3, 8'h00);
  endtask

  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    expect_reg(8'h93, 8'h00);
    expect_reg(8'hA3, 8'h00);
    expect_reg(8'h55, 8'h00);
    t_state();
    t_events();
    t_gating();
    t_threshold();
    t_buffer();
    t_valid();
    end_sim();
  end

  // a few hundred cycles are expected
  initial
  begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule // test_spectral_status_flags
